// ===== src/dam_defs.vh
// constants for the auto-mute controller
`ifndef DAM_DEFS_VH
`define DAM_DEFS_VH
// register byte offsets
`define DAM_CTRL_OFS 8'h00
`define DAM_ACT_OFS 8'h04
`define DAM_RATE_OFS 8'h08
`define DAM_ENA_OFS 8'h0c
`define DAM_WAIT_OFS 8'h10
`define DAM_GAINA_OFS 8'h14
`define DAM_GAINB_OFS 8'h18
`define DAM_DCLVL_OFS 8'h1c
`define DAM_OFFS_OFS 8'h20
`define DAM_STAT_OFS 8'h24
`define DAM_EVT_OFS 8'h28
// control register bits
`define DAM_EN_BIT 0
`define DAM_SWREQ_BIT 1
`define DAM_IGNPIN_BIT 2
`define DAM_IGNSYNC_BIT 3
`define DAM_IGNIQ_BIT 4
`define DAM_IGNALM_BIT 5
`define DAM_HOLD_BIT 6
`define DAM_RELEASE_BIT 7
// event vector positions
`define DAM_EV_ERRRPT 4
`define DAM_EV_SYNC 6
`define DAM_EV_IQINV 7
`define DAM_EV_SPD 8
`define DAM_EV_IQR 9
// mute action codes
`define DAM_ACT_HARD 2'h0
`define DAM_ACT_HOLD 2'h1
`define DAM_ACT_SOFTIQ 2'h2
`define DAM_ACT_SOFT 2'h3
// reset values
`define DAM_GAIN_RST 12'h800
`define DAM_ACT_RST 8'hff
`define DAM_RATE_RST 16'h0000
`define DAM_WAIT_RST 16'h0000
// timing: wait unit in clocks and gain step per rate interval
`define DAM_WAIT_UNIT 8
`define DAM_GAIN_STEP 12'h040
// ramp interval in clocks per rate code
`define DAM_RATE_0 16'd8
`define DAM_RATE_1 16'd16
`define DAM_RATE_2 16'd32
`define DAM_RATE_3 16'd64
`define DAM_RATE_4 16'd128
`define DAM_RATE_5 16'd256
`define DAM_RATE_6 16'd512
`define DAM_RATE_7 16'd1024
`define DAM_RATE_8 16'd2048
`define DAM_RATE_9 16'd2731
`define DAM_RATE_A 16'd4096
`define DAM_RATE_B 16'd5461
`define DAM_RATE_C 16'd8192
`define DAM_RATE_D 16'd10915
`define DAM_RATE_E 16'd16384
`define DAM_RATE_F 16'd32768
`endif

// ===== src/dam_ramp_timer.v
// ramp interval timer: one tick per mute-rate interval
`timescale 1ns/1ns
`include "dam_defs.vh"
module dam_ramp_timer #(
    parameter RATE_SHIFT = 0
) (
    // clock and reset
    input wire sys_clk,
    input wire reset,
    input wire ce,
    // control
    input wire run,
    input wire [3:0] rateCode,
    // tick
    output reg tick
);
reg [15:0] count_r;

// interval length in clocks for a rate code
function [15:0] rateLen;
    input [3:0] code;
    begin
        case (code)
            4'h0: rateLen = `DAM_RATE_0;
            4'h1: rateLen = `DAM_RATE_1;
            4'h2: rateLen = `DAM_RATE_2;
            4'h3: rateLen = `DAM_RATE_3;
            4'h4: rateLen = `DAM_RATE_4;
            4'h5: rateLen = `DAM_RATE_5;
            4'h6: rateLen = `DAM_RATE_6;
            4'h7: rateLen = `DAM_RATE_7;
            4'h8: rateLen = `DAM_RATE_8;
            4'h9: rateLen = `DAM_RATE_9;
            4'ha: rateLen = `DAM_RATE_A;
            4'hb: rateLen = `DAM_RATE_B;
            4'hc: rateLen = `DAM_RATE_C;
            4'hd: rateLen = `DAM_RATE_D;
            4'he: rateLen = `DAM_RATE_E;
            default: rateLen = `DAM_RATE_F;
        endcase
        rateLen = rateLen >> RATE_SHIFT;
        if (rateLen == 16'h0000) begin
            rateLen = 16'h0001;
        end
    end
endfunction

always @(posedge sys_clk) begin
    if (reset) begin
        count_r <= 16'h0000;
        tick <= 1'b0;
    end else if (ce) begin
        tick <= 1'b0;
        if (!run) begin
            count_r <= 16'h0000;
        end else if (count_r >= rateLen(rateCode) - 16'h0001) begin
            count_r <= 16'h0000;
            tick <= 1'b1;
        end else begin
            count_r <= count_r + 16'h0001;
        end
    end
end
endmodule // dam_ramp_timer

// ===== src/dam_auto_mute.v
// auto-mute controller with apb registers and gain ramp
// What this block does
// - enabled event in idle starts muting to zero
// - wait state keeps both gains at zero
// - wait lasts (count plus one) times eight
// - non-alarm demute only after event gone, wait elapsed
// - demute ramps gains up at rate
// - new event in demute remutes from present gains
// - idle once both gains reach initial values
// - works only while enable bit set
// - direct: software request and transmit pin
// - ten alarm events, each individually enabled
// - sync busy event stands while capture busy
// - four categories, event may join several
// - data category defaults, ignore bits remove events
// - incident events each gated by own enable
// - software request stays until written zero
// - alarm mute waits for alarm release write
// - ignore-all-alarms blocks alarm mutes, still reported
// - priority direct, alarm, data, incident
// - per-category action: hard, hold, soft+iq, soft
// - iq reset actions feed default dc levels
// - hard mute zeroes gains within one clock
// - hold freezes output, needs hold-data bit
// - soft ramps down; plain soft passes samples
// - offsets added after gain, kept when muted
// - per-category four-bit rate, 8 to 32768 clocks
`timescale 1ns/1ns
`include "dam_defs.vh"
module dam_auto_mute #(
    parameter RATE_SHIFT = 0,
    parameter WAIT_UNIT = `DAM_WAIT_UNIT
) (
    // clock, reset, enable
    input wire sys_clk,
    input wire reset,
    input wire ce,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // mute event inputs
    input wire transmitEnablePin,
    input wire [9:0] muteEvents,
    // sample path
    input wire [15:0] iSampleIn,
    input wire [15:0] qSampleIn,
    output reg [15:0] chanAOut,
    output reg [15:0] chanBOut,
    // status
    output reg [11:0] gainAOut,
    output reg [11:0] gainBOut,
    output reg muteActive
);
localparam [3:0] ST_IDLE = 4'h1;
localparam [3:0] ST_MUTE = 4'h2;
localparam [3:0] ST_WAIT = 4'h4;
localparam [3:0] ST_DEMUTE = 4'h8;
// one-hot categories
localparam [3:0] CAT_DIRECT = 4'h1;
localparam [3:0] CAT_ALARM = 4'h2;
localparam [3:0] CAT_DATA = 4'h4;
localparam [3:0] CAT_INCIDENT = 4'h8;

reg [7:0] ctrl_r;
reg [7:0] actions_r;
reg [15:0] rates_r;
reg [12:0] enables_r;
reg [15:0] waitCount_r;
reg [11:0] gainInitA_r;
reg [11:0] gainInitB_r;
reg [31:0] dcLevels_r;
reg [31:0] offsets_r;
reg releaseFlag_r;
reg [3:0] state_r;
reg [3:0] state_nxt;
reg [3:0] cat_r;
reg [1:0] action_r;
reg [3:0] rate_r;
reg [11:0] gainA_r;
reg [11:0] gainB_r;
reg [19:0] waitLeft_r;
reg holdIq_r;
reg holdOut_r;
reg [15:0] heldA_r;
reg [15:0] heldB_r;
wire rampTick;
wire wrEn;
wire setupRd;

//////////////////////////////////////////////////////////////////////
// helpers

function [1:0] actOf;
    input [7:0] acts;
    input [3:0] cat;
    begin
        if (cat[0]) begin
            actOf = acts[1:0];
        end else if (cat[1]) begin
            actOf = acts[3:2];
        end else if (cat[2]) begin
            actOf = acts[5:4];
        end else begin
            actOf = acts[7:6];
        end
    end
endfunction

function [3:0] rateOf;
    input [15:0] rates;
    input [3:0] cat;
    begin
        if (cat[0]) begin
            rateOf = rates[3:0];
        end else if (cat[1]) begin
            rateOf = rates[7:4];
        end else if (cat[2]) begin
            rateOf = rates[11:8];
        end else begin
            rateOf = rates[15:12];
        end
    end
endfunction

// gain times sample, then offset
function [15:0] scaleOut;
    input [15:0] d;
    input [11:0] g;
    input [15:0] o;
    reg signed [28:0] p;
    begin
        p = $signed(d) * $signed({1'b0, g});
        scaleOut = p[27:12] + o;
    end
endfunction

function [11:0] stepDown;
    input [11:0] g;
    begin
        if (g > `DAM_GAIN_STEP) begin
            stepDown = g - `DAM_GAIN_STEP;
        end else begin
            stepDown = 12'h000;
        end
    end
endfunction

function [11:0] stepUp;
    input [11:0] g;
    input [11:0] target;
    begin
        if (g >= target) begin
            stepUp = target;
        end else if (target - g > `DAM_GAIN_STEP) begin
            stepUp = g + `DAM_GAIN_STEP;
        end else begin
            stepUp = target;
        end
    end
endfunction

//////////////////////////////////////////////////////////////////////
// event sorting

wire muteOn = ctrl_r[`DAM_EN_BIT];
wire pinReq = transmitEnablePin & ~ctrl_r[`DAM_IGNPIN_BIT];
wire directEv = ctrl_r[`DAM_SWREQ_BIT] | pinReq;
wire [9:0] alarmVec = muteEvents & enables_r[9:0];
wire alarmEv = (|alarmVec) & ~ctrl_r[`DAM_IGNALM_BIT];
// sync busy is a level for the whole capture
wire syncEv = muteEvents[`DAM_EV_SYNC] & ~ctrl_r[`DAM_IGNSYNC_BIT];
wire iqEv = muteEvents[`DAM_EV_IQINV] & ~ctrl_r[`DAM_IGNIQ_BIT];
wire dataEv = muteEvents[`DAM_EV_ERRRPT] | syncEv | iqEv;
wire incEv = (muteEvents[`DAM_EV_ERRRPT] & enables_r[10]) |
    (muteEvents[`DAM_EV_SPD] & enables_r[11]) |
    (muteEvents[`DAM_EV_IQR] & enables_r[12]);
wire [3:0] rawCats = {incEv, dataEv, alarmEv, directEv};
reg [3:0] liveCats;
reg [3:0] pickCat;
integer k;

// hold action without hold-data bit is disregarded
always @* begin
    liveCats = 4'h0;
    for (k = 0; k < 4; k = k + 1) begin
        liveCats[k] = rawCats[k] & muteOn &
            ~(actions_r[2*k +: 2] == `DAM_ACT_HOLD &
            ~ctrl_r[`DAM_HOLD_BIT]);
    end
end

always @* begin
    if (liveCats[0]) begin
        pickCat = CAT_DIRECT;
    end else if (liveCats[1]) begin
        pickCat = CAT_ALARM;
    end else if (liveCats[2]) begin
        pickCat = CAT_DATA;
    end else begin
        pickCat = liveCats[3] ? CAT_INCIDENT : 4'h0;
    end
end

wire anyEv = |liveCats;
wire [1:0] pickAct = actOf(actions_r, pickCat);
wire [3:0] pickRate = rateOf(rates_r, pickCat);
wire catGone = ~|(liveCats & cat_r);
wire [19:0] waitLoad = ({4'h0, waitCount_r} + 20'h00001) * WAIT_UNIT[19:0] - 20'h00001;

//////////////////////////////////////////////////////////////////////
// ramp timer

dam_ramp_timer #(
    .RATE_SHIFT(RATE_SHIFT)
) rampTimer (
    .sys_clk(sys_clk),
    .reset(reset),
    .ce(ce),
    .run(state_r[1] | state_r[3]),
    .rateCode(rate_r),
    .tick(rampTick)
);

//////////////////////////////////////////////////////////////////////
// state machine

always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_IDLE: begin
            if (anyEv) begin
                state_nxt = ST_MUTE;
            end
        end
        ST_MUTE: begin
            if (gainA_r == 12'h000 && gainB_r == 12'h000) begin
                state_nxt = ST_WAIT;
            end
        end
        ST_WAIT: begin
            if (cat_r == CAT_ALARM) begin
                if (releaseFlag_r) begin
                    state_nxt = ST_DEMUTE;
                end
            end else if (catGone && waitLeft_r == 20'h00000) begin
                state_nxt = ST_DEMUTE;
            end
        end
        ST_DEMUTE: begin
            if (anyEv) begin
                state_nxt = ST_MUTE;
            end else if (gainA_r == gainInitA_r && gainB_r == gainInitB_r) begin
                state_nxt = ST_IDLE;
            end
        end
        default: state_nxt = ST_IDLE;
    endcase
    if (!muteOn) begin
        state_nxt = ST_IDLE;
    end
end

always @(posedge sys_clk) begin
    if (reset) begin
        state_r <= ST_IDLE;
        cat_r <= 4'h0;
        action_r <= `DAM_ACT_SOFT;
        rate_r <= 4'h0;
        gainA_r <= `DAM_GAIN_RST;
        gainB_r <= `DAM_GAIN_RST;
        waitLeft_r <= 20'h00000;
        holdIq_r <= 1'b0;
        holdOut_r <= 1'b0;
    end else if (ce) begin
        state_r <= state_nxt;
        if (state_nxt == ST_MUTE && !state_r[1]) begin
            cat_r <= pickCat;
            action_r <= pickAct;
            rate_r <= pickRate;
            holdIq_r <= pickAct != `DAM_ACT_SOFT;
            holdOut_r <= pickAct == `DAM_ACT_HOLD;
            if (pickAct == `DAM_ACT_HARD) begin
                gainA_r <= 12'h000;
                gainB_r <= 12'h000;
            end
        end else if (state_nxt == ST_IDLE) begin
            gainA_r <= gainInitA_r;
            gainB_r <= gainInitB_r;
            holdIq_r <= 1'b0;
            holdOut_r <= 1'b0;
        end else if (state_r[1] && rampTick) begin
            gainA_r <= stepDown(gainA_r);
            gainB_r <= stepDown(gainB_r);
        end else if (state_r[2]) begin
            gainA_r <= 12'h000;
            gainB_r <= 12'h000;
        end else if (state_r[3] && rampTick) begin
            gainA_r <= stepUp(gainA_r, gainInitA_r);
            gainB_r <= stepUp(gainB_r, gainInitB_r);
        end
        if (state_nxt == ST_DEMUTE) begin
            holdIq_r <= 1'b0;
            holdOut_r <= 1'b0;
        end
        if (state_nxt == ST_WAIT && !state_r[2]) begin
            waitLeft_r <= waitLoad;
        end else if (state_r[2] && waitLeft_r != 20'h00000) begin
            waitLeft_r <= waitLeft_r - 20'h00001;
        end
    end
end

//////////////////////////////////////////////////////////////////////
// sample path and outputs

wire [15:0] pathI = holdIq_r ? dcLevels_r[15:0] : iSampleIn;
wire [15:0] pathQ = holdIq_r ? dcLevels_r[31:16] : qSampleIn;

always @(posedge sys_clk) begin
    if (reset) begin
        chanAOut <= 16'h0000;
        chanBOut <= 16'h0000;
        heldA_r <= 16'h0000;
        heldB_r <= 16'h0000;
        gainAOut <= `DAM_GAIN_RST;
        gainBOut <= `DAM_GAIN_RST;
        muteActive <= 1'b0;
    end else if (ce) begin
        if (holdOut_r) begin
            chanAOut <= heldA_r;
            chanBOut <= heldB_r;
        end else begin
            chanAOut <= scaleOut(pathI, gainA_r, offsets_r[15:0]);
            chanBOut <= scaleOut(pathQ, gainB_r, offsets_r[31:16]);
            heldA_r <= scaleOut(pathI, gainA_r, offsets_r[15:0]);
            heldB_r <= scaleOut(pathQ, gainB_r, offsets_r[31:16]);
        end
        gainAOut <= gainA_r;
        gainBOut <= gainB_r;
        muteActive <= ~state_r[0];
    end
end

//////////////////////////////////////////////////////////////////////
// apb registers

assign wrEn = psel & penable & pready & pwrite;
assign setupRd = psel & ~penable & ~pready;

function knownAddr;
    input [7:0] a;
    begin
        knownAddr = (a <= `DAM_EVT_OFS) && (a[1:0] == 2'h0);
    end
endfunction

reg [31:0] rdMux;
always @* begin
    rdMux = 32'h00000000;
    if (paddr == `DAM_CTRL_OFS) begin
        rdMux = {24'h000000, 1'b0, ctrl_r[6:0]};
    end else if (paddr == `DAM_ACT_OFS) begin
        rdMux = {24'h000000, actions_r};
    end else if (paddr == `DAM_RATE_OFS) begin
        rdMux = {16'h0000, rates_r};
    end else if (paddr == `DAM_ENA_OFS) begin
        rdMux = {19'h00000, enables_r};
    end else if (paddr == `DAM_WAIT_OFS) begin
        rdMux = {16'h0000, waitCount_r};
    end else if (paddr == `DAM_GAINA_OFS) begin
        rdMux = {20'h00000, gainInitA_r};
    end else if (paddr == `DAM_GAINB_OFS) begin
        rdMux = {20'h00000, gainInitB_r};
    end else if (paddr == `DAM_DCLVL_OFS) begin
        rdMux = dcLevels_r;
    end else if (paddr == `DAM_OFFS_OFS) begin
        rdMux = offsets_r;
    end else if (paddr == `DAM_STAT_OFS) begin
        rdMux = {gainB_r, gainA_r, cat_r, state_r};
    end else if (paddr == `DAM_EVT_OFS) begin
        rdMux = {21'h000000, transmitEnablePin, muteEvents};
    end
end

always @(posedge sys_clk) begin
    if (reset) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        ctrl_r <= 8'h00;
        actions_r <= `DAM_ACT_RST;
        rates_r <= `DAM_RATE_RST;
        enables_r <= 13'h0000;
        waitCount_r <= `DAM_WAIT_RST;
        gainInitA_r <= `DAM_GAIN_RST;
        gainInitB_r <= `DAM_GAIN_RST;
        dcLevels_r <= 32'h00000000;
        offsets_r <= 32'h00000000;
        releaseFlag_r <= 1'b0;
    end else if (ce) begin
        pready <= setupRd;
        if (setupRd) begin
            prdata <= rdMux;
            pslverr <= ~knownAddr(paddr);
        end else begin
            pslverr <= 1'b0;
        end
        if (state_r[0]) begin
            releaseFlag_r <= 1'b0;
        end
        if (wrEn && paddr == `DAM_CTRL_OFS) begin
            ctrl_r <= {1'b0, pwdata[6:0]};
            if (pwdata[`DAM_RELEASE_BIT]) begin
                releaseFlag_r <= 1'b1;
            end
        end else if (wrEn && paddr == `DAM_ACT_OFS) begin
            actions_r <= pwdata[7:0];
        end else if (wrEn && paddr == `DAM_RATE_OFS) begin
            rates_r <= pwdata[15:0];
        end else if (wrEn && paddr == `DAM_ENA_OFS) begin
            enables_r <= pwdata[12:0];
        end else if (wrEn && paddr == `DAM_WAIT_OFS) begin
            waitCount_r <= pwdata[15:0];
        end else if (wrEn && paddr == `DAM_GAINA_OFS) begin
            gainInitA_r <= pwdata[11:0];
        end else if (wrEn && paddr == `DAM_GAINB_OFS) begin
            gainInitB_r <= pwdata[11:0];
        end else if (wrEn && paddr == `DAM_DCLVL_OFS) begin
            dcLevels_r <= pwdata;
        end else if (wrEn && paddr == `DAM_OFFS_OFS) begin
            offsets_r <= pwdata;
        end
    end
end
endmodule // dam_auto_mute

// ===== bench/dam_auto_mute_sva.sv
// assertion checker for the auto-mute controller
`timescale 1ns/1ns
module dam_auto_mute_sva #(
    parameter RATE_SHIFT = 0,
    parameter WAIT_UNIT = 8
) (
    // clock and reset
    input wire sys_clk,
    input wire reset,
    input wire ce,
    // apb
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // status
    input wire [11:0] gainAOut,
    input wire [11:0] gainBOut,
    input wire muteActive
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    a_ready_after_setup: assert property (psel && !penable && !pready && ce |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready && ce |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_no_setup: assert property (!(psel && !penable) && ce |=> !pready)
        else $error("ready without setup");
    a_error_data_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("error response with data");
    a_down_step_size: assert property (muteActive && $past(muteActive) && gainAOut < $past(gainAOut)
        |-> gainAOut == $past(gainAOut) - 12'h040 || gainAOut == 12'h000)
        else $error("bad down step");
    a_up_step_size: assert property (muteActive && $past(muteActive) && gainAOut > $past(gainAOut)
        |-> gainAOut - $past(gainAOut) <= 12'h040)
        else $error("bad up step");
    a_gains_step_together: assert property (muteActive && $past(muteActive)
        && gainAOut < $past(gainAOut) && $past(gainBOut) != 12'h000
        |-> gainBOut < $past(gainBOut))
        else $error("gains not stepped together");
    a_step_gap_min: assert property (muteActive && $past(muteActive)
        && gainAOut == $past(gainAOut) - 12'h040 |=> $stable(gainAOut) [*7])
        else $error("steps closer than eight clocks");
    a_idle_gain_settled: assert property ($fell(muteActive)
        |-> $stable(gainAOut) && $stable(gainBOut))
        else $error("idle before gains settled");

    c_slave_error: cover property (pready && pslverr);
    c_mute_start: cover property ($rose(muteActive));
    c_mute_end: cover property ($fell(muteActive));
endmodule // dam_auto_mute_sva

bind dam_auto_mute dam_auto_mute_sva #(.RATE_SHIFT(RATE_SHIFT), .WAIT_UNIT(WAIT_UNIT)) chk (
    .sys_clk(sys_clk), .reset(reset), .ce(ce), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .gainAOut(gainAOut),
    .gainBOut(gainBOut), .muteActive(muteActive));

// ===== bench/dam_host_model.sv
// host side model driving the request pin and event lines
`timescale 1ns/1ns
module dam_host_model (
    // clock and reset
    input wire sys_clk,
    input wire reset,
    // requests from the bench
    input wire pinReq,
    input wire [9:0] evtReq,
    // lines into the controller
    output reg transmitEnablePin,
    output reg [9:0] muteEvents
);
    always @(posedge sys_clk) begin
        if (reset) begin
            transmitEnablePin <= 1'b0;
            muteEvents <= 10'h000;
        end else begin
            transmitEnablePin <= pinReq;
            muteEvents <= evtReq;
        end
    end
endmodule // dam_host_model

// ===== bench/dam_tb.sv
// self-checking bench for the auto-mute controller
`timescale 1ns/1ns
`include "dam_defs.vh"
module tb;
    logic sys_clk, reset, ce, psel, penable, pwrite, pinReq, errv;
    logic [7:0] paddr;
    logic [31:0] pwdata, rdv, seed, dcv;
    logic [15:0] iS, qS, offA, offB;
    logic [9:0] evtReq;
    logic [11:0] g;
    wire [31:0] prdata;
    wire pready, pslverr, pin, act;
    wire [9:0] ev;
    wire [15:0] chA, chB;
    wire [11:0] gA, gB;
    int failures, checked, cyc, w, rc, k;

    dam_host_model host (.sys_clk(sys_clk), .reset(reset), .pinReq(pinReq), .evtReq(evtReq),
        .transmitEnablePin(pin), .muteEvents(ev));
    dam_auto_mute #(.RATE_SHIFT(0), .WAIT_UNIT(8)) dut (.sys_clk(sys_clk), .reset(reset),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .transmitEnablePin(pin), .muteEvents(ev), .iSampleIn(iS), .qSampleIn(qS),
        .chanAOut(chA), .chanBOut(chB), .gainAOut(gA), .gainBOut(gB), .muteActive(act));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function logic [15:0] outCalc(input logic [15:0] s, input logic [11:0] gn,
        input logic [15:0] o);
        logic signed [31:0] p;
        p = $signed(s) * $signed({1'b0, gn});
        return p[27:12] + o;
    endfunction

    task results();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task fail(input string nm);
        failures++;
        $display("MISMATCH %s expected done seen timeout", nm);
        results();
    endtask

    // one apb transfer, request held until ready
    task apb(input logic [7:0] a, input logic [31:0] d, input logic wr);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwdata <= d;
        pwrite <= wr;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail("pready");
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task waitAct(input logic v, input int lim);
        int n;
        n = 0;
        while (act !== v && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= lim) fail("muteActive");
    endtask

    task waitGain(input int lim);
        logic [11:0] p;
        p = gA;
        cyc = 0;
        while (gA === p && cyc < lim) begin
            @(posedge sys_clk);
            cyc++;
        end
        if (cyc >= lim) fail("gain step");
    endtask

    task quiet(input string nm);
        repeat (30) @(posedge sys_clk);
        chk(nm, 0, act);
    endtask

    initial begin
        seed = 32'h5461;
        failures = 0;
        checked = 0;
        reset = 1'b1;
        ce = 1'b1;
        {psel, penable, pwrite, pinReq, paddr, pwdata, evtReq, iS, qS} = '0;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        chk("gain reset", 12'h800, gA);
        apb(`DAM_ACT_OFS, 0, 0);
        chk("actions reset", `DAM_ACT_RST, rdv);
        apb(`DAM_RATE_OFS, 0, 0);
        chk("rates reset", `DAM_RATE_RST, rdv);
        apb(8'h2c, 0, 0);
        chk("unmapped error", 1, errv);
        chk("unmapped data", 0, rdv);
        apb(`DAM_CTRL_OFS, 32'h2, 1);
        quiet("disabled request");
        $display("test registers done");
        for (int a = 0; a < 4; a++) begin
            apb(`DAM_ACT_OFS, a, 1);
            apb(`DAM_CTRL_OFS, 32'h43, 1);
            waitAct(1'b1, 20);
            chk("gain at mute", (a == 0) ? 32'h0 : 32'h800, gA);
            while (gA !== 12'h0) waitGain(300);
            apb(`DAM_STAT_OFS, 0, 0);
            chk("status in wait", 20'h00014, rdv[19:0]);
            apb(`DAM_CTRL_OFS, 0, 0);
            chk("request kept", 1, rdv[1]);
            apb(`DAM_CTRL_OFS, 32'h41, 1);
            waitAct(1'b0, 2000);
            chk("gain restored", 12'h800, gA);
        end
        apb(`DAM_ACT_OFS, 1, 1);
        apb(`DAM_CTRL_OFS, 32'h3, 1);
        quiet("hold without data");
        apb(`DAM_CTRL_OFS, 32'h1, 1);
        $display("test actions done");
        apb(`DAM_ACT_OFS, 3, 1);
        w = rnd() % 8;
        rc = rnd() % 3;
        apb(`DAM_WAIT_OFS, w, 1);
        apb(`DAM_RATE_OFS, rc, 1);
        pinReq <= 1'b1;
        waitAct(1'b1, 20);
        pinReq <= 1'b0;
        waitGain(600);
        chk("first step", 12'h7c0, gA);
        waitGain(600);
        chk("step interval", 8 << rc, cyc);
        while (gA !== 12'h0) waitGain(600);
        waitGain(1000);
        k = (w + 1) * 8 + (8 << rc);
        chk("wait length", 1, cyc >= k && cyc <= k + 3);
        chk("up step", 12'h040, gA);
        waitGain(600);
        pinReq <= 1'b1;
        waitGain(600);
        chk("remute from present", 12'h040, gA);
        pinReq <= 1'b0;
        waitAct(1'b0, 3000);
        chk("gain idle", 12'h800, gA);
        $display("test ramps done");
        apb(`DAM_ACT_OFS, 0, 1);
        k = rnd() % 10;
        apb(`DAM_ENA_OFS, 1 << k, 1);
        evtReq[k] <= 1'b1;
        waitAct(1'b1, 20);
        evtReq <= 10'h0;
        repeat (200) @(posedge sys_clk);
        chk("alarm held", 1, act);
        apb(`DAM_STAT_OFS, 0, 0);
        chk("alarm category", 4'h2, rdv[7:4]);
        apb(`DAM_CTRL_OFS, 32'h81, 1);
        waitAct(1'b0, 1000);
        k = rnd() % 4;
        apb(`DAM_ENA_OFS, 1 << k, 1);
        apb(`DAM_CTRL_OFS, 32'h21, 1);
        evtReq[k] <= 1'b1;
        quiet("alarms ignored");
        apb(`DAM_EVT_OFS, 0, 0);
        chk("event reported", 1, rdv[k]);
        evtReq <= 10'h0;
        apb(`DAM_ENA_OFS, 0, 1);
        apb(`DAM_CTRL_OFS, 32'h1d, 1);
        pinReq <= 1'b1;
        evtReq <= 10'h0c0;
        quiet("ignored sources");
        apb(`DAM_CTRL_OFS, 32'h1, 1);
        waitAct(1'b1, 20);
        apb(`DAM_STAT_OFS, 0, 0);
        chk("priority", 4'h1, rdv[7:4]);
        pinReq <= 1'b0;
        evtReq <= 10'h0;
        waitAct(1'b0, 3000);
        evtReq <= 10'h100;
        quiet("incident disabled");
        apb(`DAM_ENA_OFS, 32'h800, 1);
        waitAct(1'b1, 20);
        apb(`DAM_STAT_OFS, 0, 0);
        chk("incident category", 4'h8, rdv[7:4]);
        evtReq <= 10'h0;
        waitAct(1'b0, 3000);
        $display("test categories done");
        offA = rnd();
        offB = rnd();
        g = rnd();
        iS <= rnd();
        qS <= rnd();
        apb(`DAM_OFFS_OFS, {offB, offA}, 1);
        apb(`DAM_GAINA_OFS, {20'h0, g}, 1);
        repeat (4) @(posedge sys_clk);
        chk("output A", outCalc(iS, g, offA), chA);
        chk("output B", outCalc(qS, 12'h800, offB), chB);
        dcv = rnd();
        apb(`DAM_DCLVL_OFS, dcv, 1);
        apb(`DAM_ACT_OFS, 2, 1);
        apb(`DAM_CTRL_OFS, 32'h3, 1);
        waitAct(1'b1, 20);
        repeat (2) @(posedge sys_clk);
        chk("default level", outCalc(dcv[15:0], g, offA), chA);
        while (gA !== 12'h0) waitGain(300);
        repeat (4) @(posedge sys_clk);
        chk("muted output", offA, chA);
        apb(`DAM_CTRL_OFS, 32'h1, 1);
        waitAct(1'b0, 3000);
        $display("test offsets done");
        results();
    end
endmodule // tb
